// [common/tpl_consts.svh]
`ifndef TPL_CONSTS_SVH
`define TPL_CONSTS_SVH

// ****************************************************************
// Clock and link timing
// ****************************************************************
`define TPL_CLK_KHZ          125000
`define TPL_LINK_MAX_US      6000
`define TPL_LINK_MIN_US      300
`define TPL_IDLE_PERIOD_US   1000
`define TPL_MAX_CYC          (`TPL_LINK_MAX_US * `TPL_CLK_KHZ / 1000)
`define TPL_MIN_CYC          ((`TPL_LINK_MIN_US * `TPL_CLK_KHZ + 999) / 1000)
`define TPL_IDLE_CYC         (`TPL_IDLE_PERIOD_US * `TPL_CLK_KHZ / 1000)

// ****************************************************************
// Link qualification counts
// ****************************************************************
`define TPL_FIRST_PULSES     16'h001f
`define TPL_MORE_PULSES      16'h0060

// ****************************************************************
// Ternary symbol codes
// ****************************************************************
`define TPL_SYM_ZERO         2'h0
`define TPL_SYM_PLUS         2'h1
`define TPL_SYM_MINUS        2'h3

// ****************************************************************
// Register map and fields
// ****************************************************************
`define TPL_REG_CTRL         12'h000
`define TPL_REG_STATUS       12'h004
`define TPL_REG_COUNT        12'h008
`define TPL_CTRL_LINK_EN     0
`define TPL_CTRL_PCS_RST     1
`define TPL_CTRL_RESET       2'h0
`define TPL_ST_PASS          4
`define TPL_ST_CARRIER       5
`define TPL_ST_TMR_DONE      6

`endif

// [common/tpl_pkg.sv]
`default_nettype none
package tpl_pkg;

	// Link integrity machine states
	typedef enum logic [2:0] {
		TPL_FAIL,
		TPL_WAIT_MORE,
		TPL_WAIT_NO_CARR,
		TPL_WAIT_CTRL,
		TPL_PASS
	} tpl_state_t;

	// Two-bit ternary symbol
	typedef logic [1:0] tpl_sym_t;

endpackage
`default_nettype wire

// [hdl/tpl_link_integrity.sv]
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tpl_consts.svh"

// Functional notes
// - Idle only on transmit pair; symbols three pairs
// - Accept symbols three pairs; idle receive-only
// - Plus, zero, minus map to 1, 0, -1
// - Retime received symbols onto symbol clock
// - Sourceless transitions checked always, take precedence
// - Maximum pulse spacing between 5 and 7 ms
// - Minimum pulse spacing between 0.15, 0.45 ms
// - Reset request holds coding sublayer in reset
// - Carrier runs always, passed only when enabled
// - Receive disabled: idle only, carrier off
// - Transmit disabled: idle, no data, pulses continue
// - Timer reloads on pulse or carrier, clears expiry
// - Timer expires after full duration without reload
// - Counter counts pulses on receive-only pair
// - Outside pass, close pulses clear counter
// - Timer expiry clears counter in any state
// - In pass, close pulses are ignored
// - Pass needs 31, 96 more, no carrier, enable; carrier in TPL_WAIT_MORE skips the 96
// - Outside pass, both gates held disabled
module tpl_link_integrity import tpl_pkg::*; #(
	parameter int MAX_CYC  = `TPL_MAX_CYC,
	parameter int MIN_CYC  = `TPL_MIN_CYC,
	parameter int IDLE_CYC = `TPL_IDLE_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_pulse_pin,
	input  wire logic [1:0]  receive_only_pair,
	input  wire logic [1:0]  bidir_pair_a_in,
	input  wire logic [1:0]  bidir_pair_b_in,
	input  wire logic        pma_carrier,
	input  wire logic        tx_data_req,
	input  wire logic [5:0]  tx_sym_req,
	output logic      [1:0]  transmit_only_pair,
	output logic      [1:0]  bidir_pair_a_out,
	output logic             bidir_pair_a_oe,
	output logic      [1:0]  bidir_pair_b_out,
	output logic             bidir_pair_b_oe,
	output logic             idle_pulse_signal,
	output logic      [5:0]  rx_sym_out,
	output logic             rx_idle,
	output logic             carrier_status,
	output logic             link_status,
	output logic             pcs_reset
);

	// ****************************************************************
	// Sized constants
	// ****************************************************************
	localparam logic [19:0] MAX_C  = 20'(MAX_CYC);
	localparam logic [15:0] MIN_C  = 16'(MIN_CYC);
	localparam logic [16:0] IDLE_C = 17'(IDLE_CYC);

	// Illegal code 2 reads as zero level
	function automatic tpl_sym_t tpl_clean(input tpl_sym_t s);
		tpl_clean = (s == 2'h2) ? `TPL_SYM_ZERO : s;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [5:0]  rx_pins;        // Receive pins, all three pairs
	logic [5:0]  rx_s1_ff;       // Sync stage one
	logic [5:0]  rx_s2_ff;       // Sync stage two
	logic [5:0]  rx_s3_ff;       // Sync stage three
	logic [5:0]  rx_sym_ff;      // Retimed, agreed symbols
	logic [2:0]  lp_sync_ff;     // Link pulse synchroniser
	logic        lp_lvl_ff;      // Agreed pulse level
	logic        lp_ev;          // One cycle per pulse
	logic        close_ev;       // Pulse inside minimum spacing
	logic        seen_ff;        // A previous pulse exists
	logic [15:0] gap_ff;         // Cycles since last pulse
	logic [19:0] tmr_ff;         // Absence timer
	logic        tmr_done_ff;    // Absence timer expired
	logic        carr_d_ff;      // Carrier, one cycle late
	logic        reload;         // Timer reload this cycle
	logic        expire;         // Timer runs out this cycle
	logic [15:0] cnt_ff;         // Link pulse count
	logic [15:0] nxt_cnt;
	tpl_state_t  state_ff;       // Link integrity state
	tpl_state_t  nxt_state;
	logic        gate_ff;        // Receive and transmit gate
	logic [1:0]  ctrl_ff;        // Control register
	logic [16:0] idle_ff;        // Idle pulse period counter
	logic        setup;          // APB setup phase
	logic        mapped;         // Address hits a register

	assign rx_pins = {bidir_pair_b_in, bidir_pair_a_in, receive_only_pair};

	// ****************************************************************
	// Receive retiming
	// ****************************************************************
	// three-stage retiming
	// Symbol changes only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_rx
			always_ff @(posedge clk) begin
				if (rst) begin
					rx_s1_ff[2*g+1:2*g]  <= `TPL_SYM_ZERO;
					rx_s2_ff[2*g+1:2*g]  <= `TPL_SYM_ZERO;
					rx_s3_ff[2*g+1:2*g]  <= `TPL_SYM_ZERO;
					rx_sym_ff[2*g+1:2*g] <= `TPL_SYM_ZERO;
				end else if (ce) begin
					rx_s1_ff[2*g+1:2*g] <= rx_pins[2*g+1:2*g];
					rx_s2_ff[2*g+1:2*g] <= rx_s1_ff[2*g+1:2*g];
					rx_s3_ff[2*g+1:2*g] <= rx_s2_ff[2*g+1:2*g];
					if (rx_s2_ff[2*g+1:2*g] == rx_s3_ff[2*g+1:2*g]) begin
						rx_sym_ff[2*g+1:2*g] <=
							tpl_clean(rx_s3_ff[2*g+1:2*g]);
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Link pulse detection
	// ****************************************************************
	// Pulse pin synchroniser and agreed level
	always_ff @(posedge clk) begin
		if (rst) begin
			lp_sync_ff <= 3'h0;
			lp_lvl_ff  <= 1'b0;
		end else if (ce) begin
			lp_sync_ff <= {lp_sync_ff[1:0], link_pulse_pin};
			if (lp_sync_ff[1] == lp_sync_ff[2]) begin
				lp_lvl_ff <= lp_sync_ff[2];
			end
		end
	end

	assign lp_ev = ce && (lp_sync_ff[1] == lp_sync_ff[2]) &&
		lp_sync_ff[2] && !lp_lvl_ff;
	assign close_ev = lp_ev && seen_ff && (gap_ff < MIN_C);

	// Spacing counter saturates at the minimum spacing
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_ff  <= 16'h0;
			seen_ff <= 1'b0;
		end else if (ce) begin
			if (lp_ev) begin
				gap_ff  <= 16'h0;
				seen_ff <= 1'b1;
			end else if (gap_ff < MIN_C) begin
				gap_ff <= gap_ff + 16'h1;
			end
		end
	end

	// ****************************************************************
	// Absence timer
	// ****************************************************************
	// Ignored close pulses do not count as valid
	assign reload = lp_ev && !close_ev || pma_carrier && !carr_d_ff && ce;
	assign expire = ce && !reload && !tmr_done_ff && (tmr_ff == 20'h1);

	// duration is the maximum spacing count
	always_ff @(posedge clk) begin
		if (rst) begin
			tmr_ff      <= MAX_C;
			tmr_done_ff <= 1'b0;
			carr_d_ff   <= 1'b0;
		end else if (ce) begin
			carr_d_ff <= pma_carrier;
			if (reload) begin
				tmr_ff      <= MAX_C;
				tmr_done_ff <= 1'b0;
			end else if (expire) begin
				tmr_ff      <= 20'h0;
				tmr_done_ff <= 1'b1;
			end else if (!tmr_done_ff) begin
				tmr_ff <= tmr_ff - 20'h1;
			end
		end
	end

	// ****************************************************************
	// Link pulse counter
	// ****************************************************************
	always_comb begin
		nxt_cnt = cnt_ff;
		if (expire) begin
			nxt_cnt = 16'h0;
		end else if (close_ev) begin
			if (state_ff != TPL_PASS) begin
				nxt_cnt = 16'h0;
			end
		end else if (lp_ev && cnt_ff != 16'hffff) begin
			nxt_cnt = cnt_ff + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 16'h0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ****************************************************************
	// Link integrity machine
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			TPL_FAIL: begin
				if (cnt_ff >= `TPL_FIRST_PULSES) begin
					nxt_state = TPL_WAIT_MORE;
				end
			end
			TPL_WAIT_MORE: begin
				if (pma_carrier ||
					cnt_ff >= `TPL_FIRST_PULSES + `TPL_MORE_PULSES) begin
					nxt_state = TPL_WAIT_NO_CARR;
				end
			end
			TPL_WAIT_NO_CARR: begin
				if (!pma_carrier) begin
					nxt_state = TPL_WAIT_CTRL;
				end
			end
			TPL_WAIT_CTRL: begin
				if (ctrl_ff[`TPL_CTRL_LINK_EN]) begin
					nxt_state = TPL_PASS;
				end
			end
			TPL_PASS: begin
				nxt_state = TPL_PASS;
			end
			default: begin
				nxt_state = TPL_FAIL;
			end
		endcase
		if (tmr_done_ff || expire || !ctrl_ff[`TPL_CTRL_LINK_EN]) begin
			nxt_state = TPL_FAIL;
		end
	end

	// State and gate registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= TPL_FAIL;
			gate_ff  <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			gate_ff  <= (nxt_state == TPL_PASS);
		end
	end

	// ****************************************************************
	// Receive side towards coding sublayer
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_sym_out     <= 6'h0;
			rx_idle        <= 1'b1;
			carrier_status <= 1'b0;
			link_status    <= 1'b0;
		end else if (ce) begin
			link_status <= gate_ff;
			rx_sym_out  <= gate_ff ? rx_sym_ff : 6'h0;
			rx_idle     <= !gate_ff;
			carrier_status <= gate_ff && pma_carrier;
		end
	end

	// ****************************************************************
	// Transmit side towards the line
	// ****************************************************************
	// Idle pulse period counter runs whenever not sending data
	always_ff @(posedge clk) begin
		if (rst) begin
			idle_ff <= 17'h0;
		end else if (ce) begin
			if (gate_ff && tx_data_req || idle_ff >= IDLE_C - 17'h1) begin
				idle_ff <= 17'h0;
			end else begin
				idle_ff <= idle_ff + 17'h1;
			end
		end
	end

	// Line drivers; bidirectional pairs released when idle
	always_ff @(posedge clk) begin
		if (rst) begin
			transmit_only_pair <= `TPL_SYM_ZERO;
			bidir_pair_a_out   <= `TPL_SYM_ZERO;
			bidir_pair_b_out   <= `TPL_SYM_ZERO;
			bidir_pair_a_oe    <= 1'b0;
			bidir_pair_b_oe    <= 1'b0;
			idle_pulse_signal  <= 1'b0;
		end else if (ce) begin
			if (gate_ff && tx_data_req) begin
				transmit_only_pair <= tpl_clean(tx_sym_req[1:0]);
				bidir_pair_a_out   <= tpl_clean(tx_sym_req[3:2]);
				bidir_pair_b_out   <= tpl_clean(tx_sym_req[5:4]);
				bidir_pair_a_oe    <= 1'b1;
				bidir_pair_b_oe    <= 1'b1;
				idle_pulse_signal  <= 1'b0;
			// idle pulses on transmit pair only
			end else begin
				transmit_only_pair <= (idle_ff == 17'h0) ?
					`TPL_SYM_PLUS : `TPL_SYM_ZERO;
				bidir_pair_a_out   <= `TPL_SYM_ZERO;
				bidir_pair_b_out   <= `TPL_SYM_ZERO;
				bidir_pair_a_oe    <= 1'b0;
				bidir_pair_b_oe    <= 1'b0;
				idle_pulse_signal  <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Register slave and sublayer reset
	// ****************************************************************
	assign setup  = psel && !penable;
	assign mapped = (paddr == `TPL_REG_CTRL) || (paddr == `TPL_REG_STATUS) ||
		(paddr == `TPL_REG_COUNT);

	// Answer is registered in setup, so access lasts one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			ctrl_ff <= `TPL_CTRL_RESET;
		end else if (ce) begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= 32'h0;
			if (setup && !pwrite) begin
				unique case (paddr)
					`TPL_REG_CTRL:   prdata <= {30'h0, ctrl_ff};
					`TPL_REG_STATUS: prdata <= {25'h0, tmr_done_ff,
						pma_carrier, gate_ff, 1'b0, state_ff};
					`TPL_REG_COUNT:  prdata <= {16'h0, cnt_ff};
					default:         prdata <= 32'h0;
				endcase
			end
			if (psel && penable && pready && pwrite &&
				paddr == `TPL_REG_CTRL) begin
				ctrl_ff <= pwdata[1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pcs_reset <= 1'b1;
		end else if (ce) begin
			pcs_reset <= ctrl_ff[`TPL_CTRL_PCS_RST];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_rx_gate_idle: assert property (
		ce && !gate_ff |=> rx_idle && rx_sym_out == 6'h0 && !carrier_status)
		else $error("receive not idle while gate closed");
	a_carrier_pass: assert property (
		ce && gate_ff && pma_carrier |=> carrier_status)
		else $error("carrier blocked while gate open");
	a_gate_pass: assert property (
		gate_ff |-> state_ff == TPL_PASS)
		else $error("gate open outside pass");
	a_tmr_reload: assert property (
		ce && reload |=> tmr_ff == MAX_C && !tmr_done_ff)
		else $error("timer not reloaded");
	a_cnt_expire: assert property (
		expire |=> cnt_ff == 16'h0 && tmr_done_ff)
		else $error("counter not cleared on expiry");
	a_cnt_close: assert property (
		close_ev && !expire && state_ff != TPL_PASS |=> cnt_ff == 16'h0)
		else $error("close pulse did not clear");
	a_cnt_ignore: assert property (
		close_ev && !expire && state_ff == TPL_PASS |=>
		cnt_ff == $past(cnt_ff))
		else $error("close pulse changed count in pass");
	a_pass_order: assert property (
		ce && state_ff != TPL_PASS && nxt_state == TPL_PASS |->
		state_ff == TPL_WAIT_CTRL && cnt_ff >= `TPL_FIRST_PULSES)
		else $error("pass reached out of order");
	a_tx_idle: assert property (
		ce && !gate_ff |=> !bidir_pair_a_oe && !bidir_pair_b_oe &&
		idle_pulse_signal)
		else $error("data sent while gate closed");
	a_fail_over: assert property (
		ce && tmr_done_ff |=> state_ff == TPL_FAIL)
		else $error("expiry did not force fail");

endmodule
`default_nettype wire

// [tb/tpl_link_integrity_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tpl_consts.svh"
module tpl_link_integrity_tb_top import tpl_pkg::*; ;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;                 // Byte address
	logic [31:0] pwdata, prdata, rd;    // Bus data, last read
	logic        err;                   // Last response error
	logic [1:0]  rx_pair, far_a, far_b; // Far-end symbols
	logic [1:0]  a_in, b_in, tx_pair, a_out, b_out;
	logic        a_oe, b_oe, idle_sig, rx_idle, carr, link_st, pcs_rst;
	logic        pma_carrier, tx_data_req, run, pulse_pin;
	logic [5:0]  tx_sym_req, rx_sym_out;
	logic [15:0] gap, sent;
	int          num_errors, samples_checked;

	// Wire level: our driver wins while enabled, else far end
	assign a_in = a_oe ? a_out : far_a;
	assign b_in = b_oe ? b_out : far_b;

	// Short counts keep the run brief: MAX 400, MIN 20, IDLE 50
	tpl_link_integrity #(.MAX_CYC(400), .MIN_CYC(20), .IDLE_CYC(50))
	tpl_link_integrity_inst (
		.clk(clk), .rst(rst), .ce(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_pulse_pin(pulse_pin),
		.receive_only_pair(rx_pair), .bidir_pair_a_in(a_in),
		.bidir_pair_b_in(b_in), .pma_carrier(pma_carrier),
		.tx_data_req(tx_data_req), .tx_sym_req(tx_sym_req),
		.transmit_only_pair(tx_pair), .bidir_pair_a_out(a_out),
		.bidir_pair_a_oe(a_oe), .bidir_pair_b_out(b_out),
		.bidir_pair_b_oe(b_oe), .idle_pulse_signal(idle_sig),
		.rx_sym_out(rx_sym_out), .rx_idle(rx_idle),
		.carrier_status(carr), .link_status(link_st),
		.pcs_reset(pcs_rst));

	tpl_partner tpl_partner_inst (.clk(clk), .rst(rst), .run(run),
		.gap(gap), .link_pulse_pin(pulse_pin), .sent(sent));

	// ****************************************
	// Tasks
	// ****************************************
	// Compare and count; x on seen never matches
	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdchk(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(n, rd, e);
	endtask

	// Send n pulses at spacing g; tail lets the last pulse finish
	task automatic send_pulses(input int n, input logic [15:0] g);
		int st;
		int k;
		st = sent;
		gap <= g;
		run <= 1'h1;
		k = 0;
		while (sent != 16'(st + n)) begin
			@(posedge clk);
			k++;
		end
		cyc(4);
		run <= 1'h0;
	endtask

	task automatic end_of_test();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial clk = 1'h0;
	always #4 clk = ~clk;

	// Tests need about 6000 cycles; generous margin
	initial begin
		cyc(40000);
		num_errors++;
		end_of_test();
	end

	initial begin : main
		int ones;
		{psel, penable, pwrite, pma_carrier, tx_data_req, run} = 6'h0;
		{paddr, pwdata, tx_sym_req, gap} = 66'h0;
		{rx_pair, far_a, far_b} = 6'h0;
		num_errors = 0;
		samples_checked = 0;
		rst = 1'h1;
		cyc(10);
		rst <= 1'h0;
		cyc(2);
		check("pcs_reset", 32'(pcs_rst), 32'h0);
		rdchk("ctrl", `TPL_REG_CTRL, 32'h0);
		rdchk("status", `TPL_REG_STATUS, 32'h0);
		rdchk("count", `TPL_REG_COUNT, 32'h0);
		apb(1'h0, 12'h00c, 32'h0);
		check("slverr", 32'(err), 32'h1);
		check("unmapped", rd, 32'h0);
		// Sublayer reset request set and cleared
		apb(1'h1, `TPL_REG_CTRL, 32'h2);
		cyc(2);
		check("pcs_reset on", 32'(pcs_rst), 32'h1);
		apb(1'h1, `TPL_REG_CTRL, 32'h1);
		cyc(2);
		check("pcs_reset off", 32'(pcs_rst), 32'h0);
		// Link down: traffic offered both ways must be blocked
		rx_pair <= 2'h1;
		far_a <= 2'h3;
		far_b <= 2'h2;
		pma_carrier <= 1'h1;
		tx_data_req <= 1'h1;
		tx_sym_req <= 6'h0d;
		ones = 0;
		repeat (100) begin
			@(posedge clk);
			if (tx_pair === 2'h1) ones++;
		end
		check("idle pulses", 32'(ones), 32'h2);
		check("rx closed", 32'(rx_sym_out), 32'h0);
		check("rx_idle", 32'(rx_idle), 32'h1);
		check("carrier off", 32'(carr), 32'h0);
		check("a_oe off", 32'(a_oe), 32'h0);
		check("b_oe off", 32'(b_oe), 32'h0);
		check("idle on", 32'(idle_sig), 32'h1);
		check("link down", 32'(link_st), 32'h0);
		{pma_carrier, tx_data_req} <= 2'h0;
		{rx_pair, far_a, far_b} <= 6'h0;
		// Pulse counting and close-pulse clearing
		send_pulses(10, 16'h001e);
		cyc(10);
		rdchk("count 10", `TPL_REG_COUNT, 32'h0a);
		cyc(40);
		send_pulses(2, 16'h000a);
		cyc(10);
		rdchk("count clr", `TPL_REG_COUNT, 32'h0);
		cyc(40);
		send_pulses(140, 16'h001e);
		cyc(10);
		rdchk("pass", `TPL_REG_STATUS, 32'h14);
		rdchk("count 140", `TPL_REG_COUNT, 32'h8c);
		check("link up", 32'(link_st), 32'h1);
		cyc(20);
		send_pulses(2, 16'h000a);
		cyc(10);
		rdchk("ignored", `TPL_REG_COUNT, 32'h8d);
		// Link up: traffic passes, pulses keep the timer alive
		fork
			send_pulses(20, 16'h001e);
			begin
				rx_pair <= 2'h1;
				far_a <= 2'h3;
				far_b <= 2'h2;
				pma_carrier <= 1'h1;
				cyc(8);
				check("rx", 32'(rx_sym_out), 32'h0d);
				check("rx open", 32'(rx_idle), 32'h0);
				check("carrier", 32'(carr), 32'h1);
				pma_carrier <= 1'h0;
				tx_data_req <= 1'h1;
				cyc(3);
				check("tx", 32'(tx_pair), 32'h1);
				check("tx a", 32'(a_out), 32'h3);
				check("tx b", 32'(b_out), 32'h0);
				check("a_oe on", 32'(a_oe), 32'h1);
				check("b_oe on", 32'(b_oe), 32'h1);
				check("idle off", 32'(idle_sig), 32'h0);
				tx_data_req <= 1'h0;
			end
		join
		// Silence: timer runs out, link drops, count clears
		cyc(450);
		rdchk("expired", `TPL_REG_STATUS, 32'h40);
		rdchk("count exp", `TPL_REG_COUNT, 32'h0);
		check("link lost", 32'(link_st), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire

// [tb/tpl_partner.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Far-end partner: sends link test pulses
// ****************************************
module tpl_partner (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [15:0] gap,
	output logic             link_pulse_pin,
	output logic [15:0]      sent
);
	logic [15:0] tick_ff; // Cycles since the last pulse began

	// Spacing counter; restarts whenever run drops
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			tick_ff <= 16'h0000;
		end else if (tick_ff == gap - 16'h0001) begin
			tick_ff <= 16'h0000;
		end else begin
			tick_ff <= tick_ff + 16'h0001;
		end
	end

	// Four cycles high so the synchroniser sees it; idles low
	always_ff @(posedge clk) begin
		link_pulse_pin <= run && !rst && (tick_ff < 16'h0004);
	end

	// Pulses sent, for the bench to pace its requests
	always_ff @(posedge clk) begin
		if (rst) begin
			sent <= 16'h0000;
		end else if (run && tick_ff == 16'h0000) begin
			sent <= sent + 16'h0001;
		end
	end
endmodule
`default_nettype wire
